//--- amg_pkg.sv
// package of constants and types for the auxiliary mix gain register bank
// Summary of operation
// - at reset each auxiliary mix register loads 8888 hex: both mutes set, both gains at the 0 dB code.
// - while any forcing condition holds, both registers stay at default and every write to them is discarded.
// - the reset pin low or the power-down pin low is a forcing condition.
// - the all-conversions-off bit of control register 0 set to 1 is a forcing condition.
// - the analog-to-mix enable bit of control register 27 at 0 is a forcing condition.
// - the analog channel power enable bit of control register 27 at 0 is a forcing condition.
// - a mute bit of 0 lets its channel into the mix, 1 silences it.
// - each gain count is 1.5 dB of attenuation: 00000 is +12 dB, 01000 is 0 dB, 11111 is -34.5 dB.
package amg_pkg;
  localparam logic [7:0] AMG_IDX_AUX_ONE = 8'h04;
  localparam logic [7:0] AMG_IDX_AUX_TWO = 8'h05;
  localparam logic [7:0] AMG_IDX_CTRL = 8'h10;
  localparam logic [7:0] AMG_IDX_STATUS = 8'h11;
  localparam logic [15:0] AMG_MIX_RESET = 16'h8888;
  localparam logic [15:0] AMG_MIX_WMASK = 16'h9f9f;
  localparam int AMG_LMUTE_BIT = 15;
  localparam int AMG_RMUTE_BIT = 7;
  localparam int AMG_LGAIN_LSB = 8;
  localparam int AMG_RGAIN_LSB = 0;
  localparam int AMG_CTRL_CONV_OFF_BIT = 0;
  localparam int AMG_CTRL_A2MIX_BIT = 1;
  localparam int AMG_CTRL_APWR_BIT = 2;
  localparam logic [2:0] AMG_CTRL_RESET = 3'h6;
  localparam logic [31:0] AMG_RDATA_NONE = 32'h0000_0000;

  typedef struct packed {
    logic mute;
    logic [4:0] gain;
  } amg_chan_s;

  typedef struct packed {
    amg_chan_s left;
    amg_chan_s right;
  } amg_mix_s;

  function automatic logic [31:0] amg_byte_addr(input logic [7:0] idx);
    amg_byte_addr = {22'h00_0000, idx, 2'b00};
  endfunction : amg_byte_addr

  function automatic amg_mix_s amg_unpack(input logic [15:0] w);
    amg_unpack.left.mute = w[AMG_LMUTE_BIT];
    amg_unpack.left.gain = w[AMG_LGAIN_LSB +: 5];
    amg_unpack.right.mute = w[AMG_RMUTE_BIT];
    amg_unpack.right.gain = w[AMG_RGAIN_LSB +: 5];
  endfunction : amg_unpack
endpackage : amg_pkg

//--- amg_mix_reg.sv
// one auxiliary mix register with forced default and write lock
module amg_mix_reg
  import amg_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic force_default,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] value_r
);
  // reserved bits never store, so they read zero whatever software writes
  always_ff @(posedge clock) begin
    if (reset || force_default) begin
      value_r <= AMG_MIX_RESET;
    end else if (wr_en) begin
      value_r <= wr_data & AMG_MIX_WMASK;
    end
  end

  property p_forced_default;
    @(posedge clock) disable iff (reset) force_default |=> value_r == AMG_MIX_RESET;
  endproperty
  a_forced_default: assert property (p_forced_default) else $error("mix register not forced to default");
  property p_hold_no_write;
    @(posedge clock) disable iff (reset) (!force_default && !wr_en) |=> $stable(value_r);
  endproperty
  a_hold_no_write: assert property (p_hold_no_write) else $error("mix register changed without a write");
endmodule : amg_mix_reg

//--- amg_aux_mix_regs.sv
// apb register bank for the two auxiliary mix controls
module amg_aux_mix_regs
  import amg_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic power_down_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output amg_mix_s aux_one_mix_r,
  output amg_mix_s aux_two_mix_r,
  output logic left_aux_one_pass_r,
  output logic right_aux_one_pass_r,
  output logic left_aux_two_pass_r,
  output logic right_aux_two_pass_r
);
  logic [1:0] rst_pin_sync_r;
  logic [1:0] pdn_sync_r;
  logic [2:0] ctrl_r;
  logic force_nxt;
  logic force_r;
  logic access;
  logic wr_one;
  logic wr_two;
  logic [15:0] aux_one_q;
  logic [15:0] aux_two_q;
  logic [31:0] rdata_nxt;
  logic hit;

  // pins are asynchronous to clock; second stage is the only reader of the first
  always_ff @(posedge clock) begin
    if (reset) begin
      rst_pin_sync_r <= 2'b00;
      pdn_sync_r <= 2'b00;
    end else begin
      rst_pin_sync_r <= {rst_pin_sync_r[0], reset_pin_n};
      pdn_sync_r <= {pdn_sync_r[0], power_down_n};
    end
  end

  assign force_nxt = !rst_pin_sync_r[1] || !pdn_sync_r[1]
    || ctrl_r[AMG_CTRL_CONV_OFF_BIT]
    || !ctrl_r[AMG_CTRL_A2MIX_BIT]
    || !ctrl_r[AMG_CTRL_APWR_BIT];

  always_ff @(posedge clock) begin
    if (reset) begin
      force_r <= 1'b1;
    end else begin
      force_r <= force_nxt;
    end
  end

  // zero wait state slave: every access phase completes in its first cycle
  assign access = psel && penable;
  assign wr_one = access && pwrite && paddr == amg_byte_addr(AMG_IDX_AUX_ONE) && !force_nxt;
  assign wr_two = access && pwrite && paddr == amg_byte_addr(AMG_IDX_AUX_TWO) && !force_nxt;

  // global control bits stand in for control registers 0 and 27
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_r <= AMG_CTRL_RESET;
    end else if (access && pwrite && paddr == amg_byte_addr(AMG_IDX_CTRL)) begin
      ctrl_r <= pwdata[2:0];
    end
  end

  amg_mix_reg u_aux_one (
    .clock(clock),
    .reset(reset),
    .force_default(force_nxt),
    .wr_en(wr_one),
    .wr_data(pwdata[15:0]),
    .value_r(aux_one_q)
  );

  amg_mix_reg u_aux_two (
    .clock(clock),
    .reset(reset),
    .force_default(force_nxt),
    .wr_en(wr_two),
    .wr_data(pwdata[15:0]),
    .value_r(aux_two_q)
  );

  always_comb begin
    hit = 1'b1;
    rdata_nxt = AMG_RDATA_NONE;
    if (paddr == amg_byte_addr(AMG_IDX_AUX_ONE)) begin
      rdata_nxt = {16'h0000, aux_one_q};
    end else if (paddr == amg_byte_addr(AMG_IDX_AUX_TWO)) begin
      rdata_nxt = {16'h0000, aux_two_q};
    end else if (paddr == amg_byte_addr(AMG_IDX_CTRL)) begin
      rdata_nxt = {29'h0000_0000, ctrl_r};
    end else if (paddr == amg_byte_addr(AMG_IDX_STATUS)) begin
      rdata_nxt = {29'h0000_0000, pdn_sync_r[1], rst_pin_sync_r[1], force_r};
    end else begin
      hit = 1'b0;
    end
  end

  // read data registered in setup, so the access phase sees stable flops
  always_ff @(posedge clock) begin
    if (reset) begin
      prdata <= AMG_RDATA_NONE;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= pwrite ? AMG_RDATA_NONE : rdata_nxt;
        pslverr <= !hit;
      end
    end
  end

  // mix path controls: decoded fields plus pass enables
  always_ff @(posedge clock) begin
    if (reset) begin
      aux_one_mix_r <= amg_unpack(AMG_MIX_RESET);
      aux_two_mix_r <= amg_unpack(AMG_MIX_RESET);
      left_aux_one_pass_r <= 1'b0;
      right_aux_one_pass_r <= 1'b0;
      left_aux_two_pass_r <= 1'b0;
      right_aux_two_pass_r <= 1'b0;
    end else begin
      aux_one_mix_r <= amg_unpack(aux_one_q);
      aux_two_mix_r <= amg_unpack(aux_two_q);
      left_aux_one_pass_r <= !aux_one_q[AMG_LMUTE_BIT];
      right_aux_one_pass_r <= !aux_one_q[AMG_RMUTE_BIT];
      left_aux_two_pass_r <= !aux_two_q[AMG_LMUTE_BIT];
      right_aux_two_pass_r <= !aux_two_q[AMG_RMUTE_BIT];
    end
  end

  property p_pin_forces;
    @(posedge clock) disable iff (reset)
      !rst_pin_sync_r[1] |=> aux_one_q == AMG_MIX_RESET && aux_two_q == AMG_MIX_RESET;
  endproperty
  a_pin_forces: assert property (p_pin_forces) else $error("reset pin did not force default");
  property p_pdn_forces;
    @(posedge clock) disable iff (reset) !pdn_sync_r[1] |=> aux_two_q == AMG_MIX_RESET;
  endproperty
  a_pdn_forces: assert property (p_pdn_forces) else $error("power down did not force default");
  property p_conv_off;
    @(posedge clock) disable iff (reset) ctrl_r[AMG_CTRL_CONV_OFF_BIT] |=> aux_one_q == AMG_MIX_RESET;
  endproperty
  a_conv_off: assert property (p_conv_off) else $error("conversions off did not force default");
  property p_a2mix;
    @(posedge clock) disable iff (reset) !ctrl_r[AMG_CTRL_A2MIX_BIT] |=> aux_one_q == AMG_MIX_RESET;
  endproperty
  a_a2mix: assert property (p_a2mix) else $error("mix enable low did not force default");
  property p_apwr;
    @(posedge clock) disable iff (reset) !ctrl_r[AMG_CTRL_APWR_BIT] |=> aux_two_q == AMG_MIX_RESET;
  endproperty
  a_apwr: assert property (p_apwr) else $error("power enable low did not force default");
  property p_write_lands;
    @(posedge clock) disable iff (reset) wr_one |=> aux_one_q == (($past(pwdata[15:0])) & AMG_MIX_WMASK);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("accepted write not stored");
  property p_mute_pass;
    @(posedge clock) disable iff (reset) ##1 left_aux_one_pass_r == !$past(aux_one_q[AMG_LMUTE_BIT]);
  endproperty
  a_mute_pass: assert property (p_mute_pass) else $error("mute does not gate the mix");
  property p_gain_field;
    @(posedge clock) disable iff (reset) ##1 aux_one_mix_r.right.gain == $past(aux_one_q[4:0]);
  endproperty
  a_gain_field: assert property (p_gain_field) else $error("right gain field misplaced");

  // both registers share one force term, so a fault in either copy shows up here
  property p_reset_loads;
    @(posedge clock) reset |=> aux_one_q == AMG_MIX_RESET && aux_two_q == AMG_MIX_RESET;
  endproperty
  a_reset_loads: assert property (p_reset_loads) else $error("reset did not load the default");
  property p_reset_muted;
    @(posedge clock) reset |=> !left_aux_one_pass_r && !right_aux_one_pass_r
      && !left_aux_two_pass_r && !right_aux_two_pass_r;
  endproperty
  a_reset_muted: assert property (p_reset_muted) else $error("a channel passes after reset");
  property p_force_both;
    @(posedge clock) disable iff (reset) force_nxt |=> aux_one_q == AMG_MIX_RESET && aux_two_q == AMG_MIX_RESET;
  endproperty
  a_force_both: assert property (p_force_both) else $error("force left a register off default");
  property p_locked_write_one;
    @(posedge clock) disable iff (reset)
      access && pwrite && paddr == amg_byte_addr(AMG_IDX_AUX_ONE) && force_nxt |=> aux_one_q == AMG_MIX_RESET;
  endproperty
  a_locked_write_one: assert property (p_locked_write_one) else $error("write landed while forced");
  property p_write_lands_two;
    @(posedge clock) disable iff (reset) wr_two |=> aux_two_q == (($past(pwdata[15:0])) & AMG_MIX_WMASK);
  endproperty
  a_write_lands_two: assert property (p_write_lands_two) else $error("second accepted write not stored");
  property p_pdn_forces_one;
    @(posedge clock) disable iff (reset) !pdn_sync_r[1] |=> aux_one_q == AMG_MIX_RESET;
  endproperty
  a_pdn_forces_one: assert property (p_pdn_forces_one) else $error("power down left first register");
  property p_conv_off_two;
    @(posedge clock) disable iff (reset) ctrl_r[AMG_CTRL_CONV_OFF_BIT] |=> aux_two_q == AMG_MIX_RESET;
  endproperty
  a_conv_off_two: assert property (p_conv_off_two) else $error("conversions off left second register");
  property p_a2mix_two;
    @(posedge clock) disable iff (reset) !ctrl_r[AMG_CTRL_A2MIX_BIT] |=> aux_two_q == AMG_MIX_RESET;
  endproperty
  a_a2mix_two: assert property (p_a2mix_two) else $error("mix enable low left second register");
  property p_apwr_one;
    @(posedge clock) disable iff (reset) !ctrl_r[AMG_CTRL_APWR_BIT] |=> aux_one_q == AMG_MIX_RESET;
  endproperty
  a_apwr_one: assert property (p_apwr_one) else $error("power enable low left first register");
  property p_mute_pass_two;
    @(posedge clock) disable iff (reset) ##1 right_aux_two_pass_r == !$past(aux_two_q[AMG_RMUTE_BIT]);
  endproperty
  a_mute_pass_two: assert property (p_mute_pass_two) else $error("right mute does not gate the mix");
  property p_gain_left_two;
    @(posedge clock) disable iff (reset) ##1 aux_two_mix_r.left.gain == $past(aux_two_q[AMG_LGAIN_LSB +: 5]);
  endproperty
  a_gain_left_two: assert property (p_gain_left_two) else $error("left gain field misplaced");
  property p_mute_field;
    @(posedge clock) disable iff (reset) ##1 aux_one_mix_r.left.mute == $past(aux_one_q[AMG_LMUTE_BIT]);
  endproperty
  a_mute_field: assert property (p_mute_field) else $error("left mute bit misplaced");
  property p_reserved_zero;
    @(posedge clock) disable iff (reset)
      (aux_one_q & ~AMG_MIX_WMASK) == 16'h0000 && (aux_two_q & ~AMG_MIX_WMASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits stored");
  property p_ready_after_setup;
    @(posedge clock) disable iff (reset) psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready in the access phase");
  property p_ready_one_cycle;
    @(posedge clock) disable iff (reset) pready |=> !pready;
  endproperty
  a_ready_one_cycle: assert property (p_ready_one_cycle) else $error("ready held past one cycle");
endmodule : amg_aux_mix_regs

//--- tb_top.sv
// self-checking testbench for the auxiliary mix gain register bank
module tb_top
  import amg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] A1 = 32'h0000_0010;
  localparam logic [31:0] A2 = 32'h0000_0014;
  logic clock, reset, reset_pin_n, power_down_n, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  amg_mix_s aux_one_mix_r, aux_two_mix_r;
  logic l1, r1, l2, r2;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  // control word that raises each forcing condition; 0 and 1 are pins, not writes
  logic [31:0] ctl_on [5] = '{32'h0000_0006, 32'h0000_0006, 32'h0000_0007, 32'h0000_0004, 32'h0000_0002};
  // status while each condition is raised: synced power-down, synced reset pin, force flag
  logic [31:0] st_on [5] = '{32'h0000_0005, 32'h0000_0003, 32'h0000_0007, 32'h0000_0007, 32'h0000_0007};

  amg_aux_mix_regs dut (.clock(clock), .reset(reset), .reset_pin_n(reset_pin_n), .power_down_n(power_down_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .aux_one_mix_r(aux_one_mix_r), .aux_two_mix_r(aux_two_mix_r),
    .left_aux_one_pass_r(l1), .right_aux_one_pass_r(r1), .left_aux_two_pass_r(l2), .right_aux_two_pass_r(r2));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      summarize();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one idle edge first, so a new setup never lands in the step that released the last one
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, {16'h0000, v}, d, e);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic exp_err, input string name);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0000_0000, d, e);
    chk(name, exp, d);
    chk({name, " error"}, {31'h0000_0000, exp_err}, {31'h0000_0000, e});
  endtask : rd_chk

  // expected decode worked out from the bit positions, independent of the package helpers
  function automatic logic [31:0] mixv(input logic [15:0] w);
    mixv = {20'h0_0000, w[15], w[12:8], w[7], w[4:0]};
  endfunction : mixv

  task automatic frc(input int k, input logic on);
    logic [31:0] d;
    logic e;
    if (k == 0) reset_pin_n <= !on;
    else if (k == 1) power_down_n <= !on;
    else apb(1'b1, 32'h0000_0040, on ? ctl_on[k] : 32'h0000_0006, d, e);
    repeat (5) @(posedge clock);
  endtask : frc

  initial begin
    reset = 1'b1;
    reset_pin_n = 1'b1;
    power_down_n = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    repeat (6) @(posedge clock);
    rd_chk(A1, 32'h0000_8888, 1'b0, "aux_one reset");
    rd_chk(A2, 32'h0000_8888, 1'b0, "aux_two reset");
    chk("aux_two_mix_r reset", mixv(16'h8888), {20'h0_0000, aux_two_mix_r});
    chk("pass reset", 32'h0000_0000, {28'h000_0000, l1, r1, l2, r2});
    rd_chk(32'h0000_0044, 32'h0000_0006, 1'b0, "status idle");
    rd_chk(32'h0000_0040, 32'h0000_0006, 1'b0, "ctrl reset");
    $display("test reset_defaults done");
    wr(A1, 16'h0a15);
    wr(A2, 16'h801f);
    repeat (2) @(posedge clock);
    rd_chk(A1, 32'h0000_0a15, 1'b0, "aux_one write");
    rd_chk(A2, 32'h0000_801f, 1'b0, "aux_two write");
    chk("aux_one_mix_r", mixv(16'h0a15), {20'h0_0000, aux_one_mix_r});
    chk("aux_two_mix_r", mixv(16'h801f), {20'h0_0000, aux_two_mix_r});
    chk("pass", 32'h0000_000d, {28'h000_0000, l1, r1, l2, r2});
    $display("test field_layout done");
    for (int k = 0; k < 5; k++) begin
      frc(k, 1'b1);
      chk("aux_one_mix_r forced", mixv(16'h8888), {20'h0_0000, aux_one_mix_r});
      rd_chk(32'h0000_0044, st_on[k], 1'b0, "status forced");
      wr(A1, 16'h0000);
      repeat (2) @(posedge clock);
      rd_chk(A1, 32'h0000_8888, 1'b0, "aux_one locked");
      rd_chk(A2, 32'h0000_8888, 1'b0, "aux_two locked");
      chk("pass forced", 32'h0000_0000, {28'h000_0000, l1, r1, l2, r2});
      frc(k, 1'b0);
      wr(A1, 16'h0a15);
      wr(A2, 16'h801f);
      rd_chk(A1, 32'h0000_0a15, 1'b0, "aux_one reopened");
      rd_chk(A2, 32'h0000_801f, 1'b0, "aux_two reopened");
      $display("test forcing condition %0d done", k);
    end
    rd_chk(32'h0000_0080, 32'h0000_0000, 1'b1, "unmapped read");
    $display("test unmapped done");
    summarize();
  end
endmodule : tb_top
